/* rsos_pkg.sv */
// How it works
// - Power request pin debounce picks 0.5, 10, 40 or 160 ms from two bits.
// - Debounce applies only when power key mode select is 1, else bypass.
// - Debounce time counts system clock cycles, not converter switching.
// - Source 00 watches no rail; output rises after the release delay.
// - Source 00 drops output on power-off sequence start or supply lockout.
// - Buck 4 disabled by the serial bus counts as buck 4 good always.
// - Source 01 drops output at once when buck 4 good falls.
// - Source 10 follows supply comparator: delayed rise, immediate fall.
// - Source 10 judges supply only while above lockout and request active.
// - Source 11 rises after all enabled rails good plus release delay.
// - Source 11 drops output at once when any monitored rail goes bad.
// - Release delay picks 100, 50, 10 or 1 ms from two bits.
// - Release delay counts system clock cycles, not converter switching.
// - Source 10 rising threshold code 2.7, 2.9, 4.0 or 4.4 V.
// - Power-on and power-off sequences share one slot of 0.5 to 16 ms.
// - Slot length counts system clock cycles, not converter switching.
package rsos_pkg;

    // =========================================================
    // Clock and counter widths
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CW = 32;
    localparam logic [CW-1:0] CNT_ZERO = 32'h0;
    localparam logic [CW-1:0] CNT_ONE = 32'h1;

    // =========================================================
    // Timer channels
    localparam int unsigned N_TMR = 3;
    localparam int unsigned TMR_DEBOUNCE = 0;
    localparam int unsigned TMR_RELEASE = 1;
    localparam int unsigned TMR_SLOT = 2;

    // =========================================================
    // Times in microseconds, indexed by the two-bit select
    localparam int unsigned DB_US_0 = 500;
    localparam int unsigned DB_US_1 = 10000;
    localparam int unsigned DB_US_2 = 40000;
    localparam int unsigned DB_US_3 = 160000;
    localparam int unsigned RD_US_0 = 100000;
    localparam int unsigned RD_US_1 = 50000;
    localparam int unsigned RD_US_2 = 10000;
    localparam int unsigned RD_US_3 = 1000;
    localparam int unsigned SL_US_0 = 500;
    localparam int unsigned SL_US_1 = 2000;
    localparam int unsigned SL_US_2 = 8000;
    localparam int unsigned SL_US_3 = 16000;

    // =========================================================
    // Mode encodings
    localparam logic [1:0] SRC_SEQ = 2'h0;
    localparam logic [1:0] SRC_BUCK4 = 2'h1;
    localparam logic [1:0] SRC_SUPPLY = 2'h2;
    localparam logic [1:0] SRC_ALL = 2'h3;
    localparam logic KEY_MODE_DEBOUNCE = 1'h1;

    // =========================================================
    // Asynchronous input vector layout
    localparam int unsigned N_RAILS = 9;
    localparam int unsigned IDX_PWR = 0;
    localparam int unsigned IDX_PG4 = 1;
    localparam int unsigned IDX_LOCK = 2;
    localparam int unsigned IDX_RISE = 3;
    localparam int unsigned IDX_RAIL = 4;
    localparam int unsigned N_ASYNC = IDX_RAIL + N_RAILS;

    // =========================================================
    // Reset output state
    typedef enum logic [1:0]
    {
        RS_HELD = 2'h0,
        RS_TIMING = 2'h1,
        RS_RELEASED = 2'h2
    } rsos_state_t;

endpackage

/* rsos_tmr_if.sv */
`timescale 1ns/1ps
// =============================================================
// Timer bank hookup
interface rsos_tmr_if;
    logic [rsos_pkg::N_TMR-1:0] run;
    logic [rsos_pkg::CW-1:0] limit [rsos_pkg::N_TMR];
    logic [rsos_pkg::N_TMR-1:0] done;
    modport ctrl (output run, output limit, input done);
    modport tmr (input run, input limit, output done);
endinterface

/* rsos_timer.sv */
`timescale 1ns/1ps
// =============================================================
// Restartable interval counters, one per channel
module rsos_timer
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Channel controls
    rsos_tmr_if.tmr t
);

    logic [rsos_pkg::CW-1:0] cnt_q [rsos_pkg::N_TMR];
    logic [rsos_pkg::CW-1:0] cnt_d [rsos_pkg::N_TMR];
    logic [rsos_pkg::N_TMR-1:0] done_q;
    logic [rsos_pkg::N_TMR-1:0] done_d;

    genvar i;
    generate
        for (i = 0; i < rsos_pkg::N_TMR; i++)
        begin : g_ch
            // Count while running, pulse and wrap at the limit
            always_comb
            begin
                cnt_d[i] = rsos_pkg::CNT_ZERO;
                done_d[i] = 1'b0;
                if (!t.run[i])
                begin
                    cnt_d[i] = rsos_pkg::CNT_ZERO;
                end
                else if (cnt_q[i] >= t.limit[i] - rsos_pkg::CNT_ONE)
                begin
                    done_d[i] = 1'b1;
                end
                else
                begin
                    cnt_d[i] = cnt_q[i] + rsos_pkg::CNT_ONE;
                end
            end

            // Counter registers
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    cnt_q[i] <= rsos_pkg::CNT_ZERO;
                    done_q[i] <= 1'b0;
                end
                else
                begin
                    cnt_q[i] <= cnt_d[i];
                    done_q[i] <= done_d[i];
                end
            end
        end
    endgenerate

    assign t.done = done_q;

endmodule

/* rsos_supervisor.sv */
`timescale 1ns/1ps
// =============================================================
// Reset output supervisor: key debounce, reset output, slot timing
module rsos_supervisor
#(
    parameter int unsigned DB_CYC [4] = '{
        rsos_pkg::DB_US_0 * rsos_pkg::CLK_MHZ,
        rsos_pkg::DB_US_1 * rsos_pkg::CLK_MHZ,
        rsos_pkg::DB_US_2 * rsos_pkg::CLK_MHZ,
        rsos_pkg::DB_US_3 * rsos_pkg::CLK_MHZ},
    parameter int unsigned RD_CYC [4] = '{
        rsos_pkg::RD_US_0 * rsos_pkg::CLK_MHZ,
        rsos_pkg::RD_US_1 * rsos_pkg::CLK_MHZ,
        rsos_pkg::RD_US_2 * rsos_pkg::CLK_MHZ,
        rsos_pkg::RD_US_3 * rsos_pkg::CLK_MHZ},
    parameter int unsigned SL_CYC [4] = '{
        rsos_pkg::SL_US_0 * rsos_pkg::CLK_MHZ,
        rsos_pkg::SL_US_1 * rsos_pkg::CLK_MHZ,
        rsos_pkg::SL_US_2 * rsos_pkg::CLK_MHZ,
        rsos_pkg::SL_US_3 * rsos_pkg::CLK_MHZ}
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Power request pin and key mode
    input wire logic power_request_pin,
    input wire logic power_key_mode_select,
    input wire logic [1:0] power_request_debounce_sel,
    // Reset output configuration
    input wire logic [1:0] reset_out_source_select,
    input wire logic [1:0] reset_release_delay_sel,
    input wire logic [1:0] input_rise_threshold_sel,
    // Supply comparators, asynchronous
    input wire logic main_supply_above_lockout,
    input wire logic main_supply_above_rise,
    // Rail status, flags asynchronous
    input wire logic buck4_power_good_flag,
    input wire logic buck4_bus_disabled,
    input wire logic [rsos_pkg::N_RAILS-1:0] rail_enable,
    input wire logic [rsos_pkg::N_RAILS-1:0] rail_good_flag,
    // Sequencer
    input wire logic power_off_seq_active,
    input wire logic sequence_running,
    input wire logic [1:0] sequence_slot_length_sel,
    // Outputs
    output logic reset_output_pin,
    output logic power_request_active,
    output logic [1:0] rise_threshold_code,
    output logic slot_tick
);

    rsos_tmr_if tmr ();

    rsos_timer u_timer
    (
        .clk (clk),
        .reset (reset),
        .t (tmr.tmr)
    );

    // =========================================================
    // Input synchronisers
    logic [rsos_pkg::N_ASYNC-1:0] async_in;
    logic [rsos_pkg::N_ASYNC-1:0] s1_q;
    logic [rsos_pkg::N_ASYNC-1:0] s2_q;
    logic [rsos_pkg::N_ASYNC-1:0] s3_q;
    logic [rsos_pkg::N_ASYNC-1:0] filt_q;
    logic [rsos_pkg::N_ASYNC-1:0] filt_d;

    // Gather the pins into one vector
    assign async_in = {rail_good_flag, main_supply_above_rise,
        main_supply_above_lockout, buck4_power_good_flag,
        power_request_pin};

    // Accept a level once stages two and three agree
    genvar b;
    generate
        for (b = 0; b < rsos_pkg::N_ASYNC; b++)
        begin : g_filt
            assign filt_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : filt_q[b];
        end
    endgenerate

    // Synchroniser registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    logic pwr_sync;
    logic pg4_sync;
    logic lock_ok;
    logic rise_ok;
    logic [rsos_pkg::N_RAILS-1:0] rail_sync;

    assign pwr_sync = filt_q[rsos_pkg::IDX_PWR];
    assign pg4_sync = filt_q[rsos_pkg::IDX_PG4];
    assign lock_ok = filt_q[rsos_pkg::IDX_LOCK];
    assign rise_ok = filt_q[rsos_pkg::IDX_RISE];
    assign rail_sync = filt_q[rsos_pkg::IDX_RAIL +: rsos_pkg::N_RAILS];

    // =========================================================
    // Power request debounce
    logic pwr_act_q;
    logic pwr_act_d;
    logic db_mode;
    logic db_mismatch;
    logic db_done;

    assign db_mode = (power_key_mode_select == rsos_pkg::KEY_MODE_DEBOUNCE);
    assign db_mismatch = (pwr_sync != pwr_act_q);
    assign db_done = tmr.done[rsos_pkg::TMR_DEBOUNCE];

    // Follow the pin directly or after a stable interval
    always_comb
    begin
        pwr_act_d = pwr_act_q;
        if (!db_mode)
        begin
            pwr_act_d = pwr_sync;
        end
        else if (db_mismatch && db_done)
        begin
            pwr_act_d = pwr_sync;
        end
    end

    // Debounced request register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pwr_act_q <= 1'b0;
        end
        else
        begin
            pwr_act_q <= pwr_act_d;
        end
    end

    // =========================================================
    // Reset output condition per source
    logic pg4_eff;
    logic rails_ok;
    logic rso_good;

    assign pg4_eff = buck4_bus_disabled | pg4_sync;
    assign rails_ok = &(~rail_enable | rail_sync);

    // Pick the condition the output follows
    always_comb
    begin
        case (reset_out_source_select)
            rsos_pkg::SRC_SEQ:
                rso_good = lock_ok & ~power_off_seq_active;
            rsos_pkg::SRC_BUCK4:
                rso_good = pg4_eff;
            rsos_pkg::SRC_SUPPLY:
                rso_good = lock_ok & pwr_act_q & rise_ok;
            rsos_pkg::SRC_ALL:
                rso_good = rails_ok;
            default:
                rso_good = 1'b0;
        endcase
    end

    // =========================================================
    // Reset output state machine
    rsos_pkg::rsos_state_t st_q;
    rsos_pkg::rsos_state_t st_d;
    logic rso_q;
    logic rso_d;
    logic rd_done;

    assign rd_done = tmr.done[rsos_pkg::TMR_RELEASE];

    // Delayed release, immediate assertion
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            rsos_pkg::RS_HELD:
            begin
                if (rso_good)
                begin
                    st_d = rsos_pkg::RS_TIMING;
                end
            end
            rsos_pkg::RS_TIMING:
            begin
                if (!rso_good)
                begin
                    st_d = rsos_pkg::RS_HELD;
                end
                else if (rd_done)
                begin
                    st_d = rsos_pkg::RS_RELEASED;
                end
            end
            rsos_pkg::RS_RELEASED:
            begin
                if (!rso_good)
                begin
                    st_d = rsos_pkg::RS_HELD;
                end
            end
            default:
                st_d = rsos_pkg::RS_HELD;
        endcase
        rso_d = (st_d == rsos_pkg::RS_RELEASED);
    end

    // State and pin registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= rsos_pkg::RS_HELD;
            rso_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            rso_q <= rso_d;
        end
    end

    // =========================================================
    // Timer hookup and slot tick
    logic tick_q;
    logic thr_q;
    logic [1:0] thr_code_q;

    // Drive timer channels from the selects
    always_comb
    begin
        tmr.run[rsos_pkg::TMR_DEBOUNCE] = db_mode & db_mismatch;
        tmr.limit[rsos_pkg::TMR_DEBOUNCE] =
            DB_CYC[power_request_debounce_sel];
        tmr.run[rsos_pkg::TMR_RELEASE] =
            (st_q == rsos_pkg::RS_TIMING) & rso_good;
        tmr.limit[rsos_pkg::TMR_RELEASE] =
            RD_CYC[reset_release_delay_sel];
        tmr.run[rsos_pkg::TMR_SLOT] = sequence_running;
        tmr.limit[rsos_pkg::TMR_SLOT] =
            SL_CYC[sequence_slot_length_sel];
    end

    // Slot tick and threshold code registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tick_q <= 1'b0;
            thr_code_q <= 2'h0;
        end
        else
        begin
            tick_q <= tmr.done[rsos_pkg::TMR_SLOT] & sequence_running;
            thr_code_q <= input_rise_threshold_sel;
        end
    end

    assign reset_output_pin = rso_q;
    assign power_request_active = pwr_act_q;
    assign rise_threshold_code = thr_code_q;
    assign slot_tick = tick_q;

    // =========================================================
    // Assertion helpers: consecutive-cycle counters
    logic [rsos_pkg::CW-1:0] mis_cnt_q;
    logic [rsos_pkg::CW-1:0] good_cnt_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mis_cnt_q <= rsos_pkg::CNT_ZERO;
            good_cnt_q <= rsos_pkg::CNT_ZERO;
        end
        else
        begin
            mis_cnt_q <= db_mismatch ? mis_cnt_q + rsos_pkg::CNT_ONE
                : rsos_pkg::CNT_ZERO;
            good_cnt_q <= rso_good ? good_cnt_q + rsos_pkg::CNT_ONE
                : rsos_pkg::CNT_ZERO;
        end
    end

    // =========================================================
    // Assertions
    property p_db_bypass;
        @(posedge clk) disable iff (reset)
        !db_mode |=> (power_request_active == $past(pwr_sync));
    endproperty
    a_db_bypass: assert property (p_db_bypass)
        else $error("request not following pin in bypass mode");

    property p_db_stable;
        @(posedge clk) disable iff (reset)
        (db_mode && $past(db_mode) && $changed(power_request_active))
        |-> ($past(mis_cnt_q) >= $past(tmr.limit[rsos_pkg::TMR_DEBOUNCE]));
    endproperty
    a_db_stable: assert property (p_db_stable)
        else $error("request changed before debounce time");

    property p_drop_now;
        @(posedge clk) disable iff (reset)
        !rso_good |=> !reset_output_pin;
    endproperty
    a_drop_now: assert property (p_drop_now)
        else $error("reset output not lowered at once");

    property p_rise_delay;
        @(posedge clk) disable iff (reset)
        $rose(reset_output_pin) |->
            ($past(good_cnt_q) >= $past(tmr.limit[rsos_pkg::TMR_RELEASE]));
    endproperty
    a_rise_delay: assert property (p_rise_delay)
        else $error("reset output rose before release delay");

    property p_buck4_off;
        @(posedge clk) disable iff (reset)
        (reset_out_source_select == rsos_pkg::SRC_BUCK4
            && buck4_bus_disabled && reset_output_pin) |=> reset_output_pin;
    endproperty
    a_buck4_off: assert property (p_buck4_off)
        else $error("disabled buck 4 not seen as good");

    property p_supply_off;
        @(posedge clk) disable iff (reset)
        (reset_out_source_select == rsos_pkg::SRC_SUPPLY
            && !power_request_active) |=> !reset_output_pin;
    endproperty
    a_supply_off: assert property (p_supply_off)
        else $error("supply mode high while request inactive");

    property p_seq_off;
        @(posedge clk) disable iff (reset)
        (reset_out_source_select == rsos_pkg::SRC_SEQ
            && power_off_seq_active) |=> !reset_output_pin;
    endproperty
    a_seq_off: assert property (p_seq_off)
        else $error("reset output high during power-off");

    property p_rails_bad;
        @(posedge clk) disable iff (reset)
        (reset_out_source_select == rsos_pkg::SRC_ALL && !rails_ok)
        |=> !reset_output_pin;
    endproperty
    a_rails_bad: assert property (p_rails_bad)
        else $error("reset output high with a rail bad");

    property p_slot_pulse;
        @(posedge clk) disable iff (reset)
        slot_tick |=> !slot_tick;
    endproperty
    a_slot_pulse: assert property (p_slot_pulse)
        else $error("slot tick longer than one cycle");

endmodule

/* rsos_host_model.sv */
`timescale 1ns/1ps
// =============================================================
// Host side: drives the power request pin, watches reset release
module rsos_host_model
(
    // Clock
    input wire logic clk,
    // Reset release from the supervisor
    input wire logic reset_output_pin,
    // Power request toward the supervisor
    output logic power_request_pin
);
    int n_release = 0;

    initial
    begin
        power_request_pin = 1'h0;
    end

    // Request level changes only just after a falling edge
    task automatic set_req(input logic v);
        @(negedge clk);
        power_request_pin = v;
    endtask

    // Count reset releases seen by the host
    always @(posedge reset_output_pin)
    begin
        n_release++;
    end
endmodule

/* test_reset_output_supervisor.sv */
`timescale 1ns/1ps
// =============================================================
// Self-checking bench for the reset output supervisor
module test_reset_output_supervisor;
    localparam int unsigned DB [4] = '{20, 30, 40, 50};
    localparam int unsigned RD [4] = '{40, 30, 20, 10};
    localparam int unsigned SL [4] = '{8, 12, 16, 20};

    logic clk = 1'h0;
    logic reset = 1'h1;
    logic key = 1'h0;
    logic [1:0] dbs = 2'h0;
    logic [1:0] src = 2'h0;
    logic [1:0] dly = 2'h0;
    logic [1:0] thr = 2'h2;
    logic lock = 1'h1;
    logic rise = 1'h1;
    logic pg4 = 1'h1;
    logic bdis = 1'h0;
    logic [8:0] en = 9'h000;
    logic [8:0] good = 9'h1FF;
    logic poff = 1'h0;
    logic run = 1'h0;
    logic [1:0] sls = 2'h0;
    logic pin;
    logic rst_o;
    logic req_o;
    logic [1:0] thr_o;
    logic tick;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 32'h4c2c;
    int n;

    // =========================================================
    // Clock and instances
    always #4 clk = ~clk;

    rsos_supervisor #(.DB_CYC(DB), .RD_CYC(RD), .SL_CYC(SL)) u_rsos_supervisor
    (
        .clk(clk), .reset(reset),
        .power_request_pin(pin), .power_key_mode_select(key),
        .power_request_debounce_sel(dbs), .reset_out_source_select(src),
        .reset_release_delay_sel(dly), .input_rise_threshold_sel(thr),
        .main_supply_above_lockout(lock), .main_supply_above_rise(rise),
        .buck4_power_good_flag(pg4), .buck4_bus_disabled(bdis),
        .rail_enable(en), .rail_good_flag(good),
        .power_off_seq_active(poff), .sequence_running(run),
        .sequence_slot_length_sel(sls), .reset_output_pin(rst_o),
        .power_request_active(req_o), .rise_threshold_code(thr_o),
        .slot_tick(tick)
    );

    rsos_host_model u_rsos_host_model
    (
        .clk(clk), .reset_output_pin(rst_o), .power_request_pin(pin)
    );

    // =========================================================
    // Checking helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] lo,
                       input logic [31:0] hi);
        cmp_count++;
        if ($isunknown(g) || g < lo || g > hi)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo);
        end
    endtask

    function automatic logic sig(input int w);
        return (w == 0) ? rst_o : (w == 1) ? req_o : tick;
    endfunction

    // Edges until an output reaches a level, bounded
    task automatic meas(input int w, input logic v, input int lo,
                        input int hi);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (sig(w) !== v && n < 1000);
        chk(n, lo, hi);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #800000;
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 0, 1);
        test_done();
    end

    // =========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'h0;
        // Threshold code passes through
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            thr = i[1:0];
            repeat (2) @(posedge clk);
            #1;
            chk(thr_o, i, i);
        end
        $display("test threshold done");
        // Debounce every setting, plus a short glitch
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            key = 1'h1;
            dbs = i[1:0];
            u_rsos_host_model.set_req(1'h1);
            meas(1, 1'h1, DB[i] + 3, DB[i] + 8);
            u_rsos_host_model.set_req(1'h0);
            meas(1, 1'h0, DB[i] + 3, DB[i] + 8);
            u_rsos_host_model.set_req(1'h1);
            repeat (DB[i] / 2) @(posedge clk);
            #1 chk(req_o, 0, 0);
            u_rsos_host_model.set_req(1'h0);
            repeat (DB[i] + 10) @(posedge clk);
            #1 chk(req_o, 0, 0);
        end
        // Bypass mode follows the pin quickly
        @(negedge clk);
        key = 1'h0;
        u_rsos_host_model.set_req(1'h1);
        meas(1, 1'h1, 1, 6);
        $display("test debounce done");
        // Source 00: lockout, power-off, every delay
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            dly = i[1:0];
            lock = 1'h0;
            meas(0, 1'h0, 1, 6);
            @(negedge clk);
            lock = 1'h1;
            meas(0, 1'h1, RD[i] + 3, RD[i] + 8);
            @(negedge clk);
            poff = 1'h1;
            meas(0, 1'h0, 1, 3);
            @(negedge clk);
            poff = 1'h0;
            meas(0, 1'h1, RD[i] + 1, RD[i] + 8);
        end
        $display("test source seq done");
        // Source 01: buck 4 good, disabled by bus
        @(negedge clk);
        src = 2'h1;
        dly = 2'($random(seed));
        poff = 1'($random(seed));
        rise = 1'($random(seed));
        pg4 = 1'h0;
        meas(0, 1'h0, 1, 6);
        @(negedge clk);
        pg4 = 1'h1;
        meas(0, 1'h1, RD[dly] + 3, RD[dly] + 8);
        @(negedge clk);
        bdis = 1'h1;
        pg4 = 1'h0;
        repeat (20) @(posedge clk);
        #1 chk(rst_o, 1, 1);
        @(negedge clk);
        bdis = 1'h0;
        meas(0, 1'h0, 1, 6);
        @(negedge clk);
        pg4 = 1'h1;
        poff = 1'h0;
        rise = 1'h1;
        $display("test source buck4 done");
        // Source 10: rise comparator and request gating
        @(negedge clk);
        src = 2'h2;
        meas(0, 1'h1, 1, RD[dly] + 8);
        @(negedge clk);
        rise = 1'h0;
        meas(0, 1'h0, 1, 6);
        @(negedge clk);
        rise = 1'h1;
        meas(0, 1'h1, RD[dly] + 3, RD[dly] + 8);
        u_rsos_host_model.set_req(1'h0);
        meas(0, 1'h0, 1, 8);
        u_rsos_host_model.set_req(1'h1);
        meas(0, 1'h1, RD[dly] + 3, RD[dly] + 9);
        $display("test source supply done");
        // Source 11: enabled rails only, restart on a dropout
        @(negedge clk);
        src = 2'h3;
        en = 9'($random(seed));
        en[0] = 1'h1;
        en[1] = 1'h0;
        good = 9'($random(seed)) | en;
        good[1] = 1'h0;
        bdis = 1'($random(seed));
        pg4 = 1'($random(seed));
        repeat (20) @(posedge clk);
        #1 chk(rst_o, 1, 1);
        @(negedge clk);
        good[0] = 1'h0;
        meas(0, 1'h0, 1, 6);
        @(negedge clk);
        good[0] = 1'h1;
        repeat (RD[dly] / 2) @(posedge clk);
        @(negedge clk);
        good[0] = 1'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        good[0] = 1'h1;
        meas(0, 1'h1, RD[dly] + 3, RD[dly] + 8);
        @(negedge clk);
        good[1] = 1'h1;
        $display("test source rails done");
        // Slot ticks for every length
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            sls = i[1:0];
            run = 1'h1;
            meas(2, 1'h1, SL[i], SL[i] + 2);
            meas(2, 1'h1, SL[i], SL[i]);
            @(negedge clk);
            run = 1'h0;
            repeat (4) @(posedge clk);
        end
        $display("test slot done");
        chk(u_rsos_host_model.n_release, 14, 14);
        test_done();
    end
endmodule
